/* pkg/rom_pkg.sv */
// Package for the relay output matrix and supervision block.
// Holds parameter codes of the parallel parameter port, reset values,
// selector encodings and timing figures; no logic lives here.
package rom_pkg;
  // Clock rate of mclk_i
  localparam int unsigned CLK_HZ          = 25_000_000;
  // Blink half period of the ready indicator, in ms
  localparam int unsigned BLINK_HALF_MS   = 250;
  localparam int unsigned BLINK_HALF_CYC  = CLK_HZ / 1000 * BLINK_HALF_MS;
  // Restart pulse length and recovery settle time, in us
  localparam int unsigned RESTART_US      = 1000;
  localparam int unsigned RESTART_CYC     = CLK_HZ / 1_000_000 * RESTART_US;
  localparam int unsigned SETTLE_US       = 10000;
  localparam int unsigned SETTLE_CYC      = CLK_HZ / 1_000_000 * SETTLE_US;

  // Parameter codes on the parameter port
  localparam logic [7:0] P_MEAS_U0     = 8'h01; // Residual voltage
  localparam logic [7:0] P_MEAS_I0     = 8'h02; // Earth-fault current
  localparam logic [7:0] P_MEAS_IDIR   = 8'h03; // Directional current
  localparam logic [7:0] P_MEAS_ANGLE  = 8'h04; // Phase angle
  localparam logic [7:0] P_BIN_STATE   = 8'h05; // Binary input state
  localparam logic [7:0] P_STAGE_BASE  = 8'h11; // Six stage flags
  localparam logic [7:0] P_CONT_BASE   = 8'h17; // Four contact states
  localparam logic [7:0] P_REC_BASE    = 8'h21; // Ten recorded flags
  localparam logic [7:0] P_ENABLE      = 8'h41; // Global contact enable
  localparam logic [7:0] P_GROUP_BASE  = 8'h51; // Six routing groups
  localparam logic [7:0] P_BIN_FUNC    = 8'h60; // Binary input function
  localparam logic [7:0] P_NOM_VOLT    = 8'h61; // Nominal voltage select
  localparam logic [7:0] P_REC_TRIG    = 8'h62; // Recorder trigger select
  localparam logic [7:0] P_REC_CLEAR   = 8'h63; // Recorded flag clear mask
  localparam logic [7:0] P_FAULT_CLEAR = 8'h64; // Fault message clear
  localparam logic [7:0] P_FAULT_CODE  = 8'h65; // Last fault code

  // Phase angle stand-in when the inputs are too small
  localparam logic [15:0] ANGLE_INVALID = 16'h03E7;
  // Routing group reset: trip groups to both trip contacts,
  // start groups to both signalling contacts
  localparam logic [3:0] GRP_TRIP_RST  = 4'h3;
  localparam logic [3:0] GRP_START_RST = 4'hC;
  localparam logic       ENABLE_RST    = 1'h1;
  localparam logic [1:0] NOM_VOLT_RST  = 2'h0;

  // Binary input functions
  typedef enum logic [1:0] {
    ROM_BI_NONE,
    ROM_BI_BLOCK,
    ROM_BI_UNLATCH,
    ROM_BI_SETTINGS
  } rom_bi_func_t;
endpackage : rom_pkg

/* test/rom_checker.sv */
// Timing checker of the relay output block, bound to rom_top.
// Assumes the bench shortens the restart and settle counts.
`timescale 1ns/1ps
`default_nettype none
module rom_checker #(
  parameter int unsigned RESTART_CYC = 3, // Restart window
  parameter int unsigned SETTLE_CYC  = 5  // Settle window
) (
  input wire logic       mclk_i,
  input wire logic       rst_b_i,
  input wire logic       fault_i,
  input wire logic       par_rd_i,
  input wire logic       par_wr_i,
  input wire logic [7:0] par_sel_i,
  input wire logic       par_ack_o,
  input wire logic       trip_a_o,
  input wire logic       trip_b_o,
  input wire logic       sig_a_o,
  input wire logic       sig_b_o,
  input wire logic       sup_energ_o,
  input wire logic       ready_led_o,
  input wire logic       fault_msg_o,
  input wire logic [1:0] ind_o,
  input wire logic       restart_o,
  input wire logic       rec_trig_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);
  logic       clr_w;    // Fault message clear write
  logic [7:0] hi_cnt_r; // Cycles with fault held
  assign clr_w = par_wr_i && (par_sel_i == rom_pkg::P_FAULT_CLEAR);
  // Saturates so a long fault never wraps back into range
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) hi_cnt_r <= 8'h00;
    else if (!fault_i) hi_cnt_r <= 8'h00;
    else if (hi_cnt_r != 8'hFF) hi_cnt_r <= hi_cnt_r + 8'h01;
  end
  a_ack_follows: assert property ((par_rd_i || par_wr_i) |=> par_ack_o)
    else $error("ack missing after access");
  a_ack_single: assert property (!(par_rd_i || par_wr_i) |=> !par_ack_o)
    else $error("ack without access");
  a_restart_first: assert property ($rose(fault_i) |-> ##[1:2] restart_o)
    else $error("no restart after fault");
  a_coil_held: assert property ($rose(fault_i) |=> sup_energ_o [*3])
    else $error("coil dropped before restart");
  a_perm_bound: assert property
    (hi_cnt_r >= RESTART_CYC + SETTLE_CYC + 4 |-> !sup_energ_o)
    else $error("coil still on in lasting fault");
  a_perm_msg: assert property ($fell(sup_energ_o) |-> ##[0:1] fault_msg_o)
    else $error("no fault message");
  a_ready_healthy: assert property
    (sup_energ_o && $past(sup_energ_o) |-> ready_led_o)
    else $error("ready off while healthy");
  a_gone_coil: assert property (!fault_i [*3] |-> sup_energ_o)
    else $error("coil off without fault");
  a_msg_sticky: assert property
    (fault_msg_o && !clr_w && !$past(clr_w) |=> fault_msg_o)
    else $error("fault message lost");
  a_clear_blocked: assert property
    (!sup_energ_o && fault_msg_o && clr_w |=> fault_msg_o [*2])
    else $error("message cleared while blinking");
  a_ind_quiet: assert property (fault_msg_o ##1 fault_msg_o |-> ind_o == 2'h0)
    else $error("indicator over fault message");
  a_fault_blocks: assert property (fault_i ##1 fault_i |=>
    !(trip_a_o || trip_b_o || sig_a_o || sig_b_o))
    else $error("contact closed in fault");
  a_trig_pulse: assert property (rec_trig_o |=> !rec_trig_o)
    else $error("trigger longer than a pulse");
endmodule : rom_checker
bind rom_top rom_checker #(.RESTART_CYC(RESTART_CYC),
  .SETTLE_CYC(SETTLE_CYC)) u_chk (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
  .fault_i(fault_i), .par_rd_i(par_rd_i), .par_wr_i(par_wr_i),
  .par_sel_i(par_sel_i), .par_ack_o(par_ack_o), .trip_a_o(trip_a_o),
  .trip_b_o(trip_b_o), .sig_a_o(sig_a_o), .sig_b_o(sig_b_o),
  .sup_energ_o(sup_energ_o), .ready_led_o(ready_led_o),
  .fault_msg_o(fault_msg_o), .ind_o(ind_o), .restart_o(restart_o),
  .rec_trig_o(rec_trig_o));
`default_nettype wire

/* test/rom_host_model.sv */
// Host at the far end of the parameter port.
// Assumes its caller starts each access after a falling edge.
`timescale 1ns/1ps
`default_nettype none
module rom_host_model (
  input  wire logic  mclk_i,  // System clock
  input  wire logic  ack_i,   // Access done
  output logic       rd_o,    // Read strobe
  output logic       wr_o,    // Write strobe
  output logic [7:0] sel_o,   // Parameter code
  output logic [15:0] wdata_o // Write data
);
  // Idle port
  initial {rd_o, wr_o, sel_o, wdata_o} = '0;
  // One access; waits for ack so a slow answer is tolerated
  task automatic xfer(input logic w, input logic [7:0] s,
                      input logic [15:0] d);
    int n;
    @(negedge mclk_i);
    rd_o    = !w;
    wr_o    = w;
    sel_o   = s;
    wdata_o = d;
    @(negedge mclk_i);
    rd_o = 1'b0;
    wr_o = 1'b0;
    n    = 0;
    while (ack_i !== 1'b1 && n < 8) begin
      @(negedge mclk_i);
      n++;
    end
    // Released lines show no stale value
    sel_o   = ~s;
    wdata_o = ~d;
  endtask : xfer
endmodule : rom_host_model
`default_nettype wire

/* test/test_relay_output_matrix_and_supervision.sv */
// Self-checking bench of the relay output block.
// Assumes rom_top with shortened blink, restart and settle counts.
`timescale 1ns/1ps
`default_nettype none
module test_relay_output_matrix_and_supervision;
  localparam int unsigned BL = 4; // Short blink half period
  logic        clk, rst_b, ang_ok, bin, flt, rd, wr, ack;
  logic        ta, tb, sa, sb, sup, rdy, msg, rq, blk, bank, trg;
  logic [15:0] u0, i0, idir, ang, wd, rdata;
  logic [2:0]  st, tr;
  logic [7:0]  fcode, sel;
  logic [1:0]  ind, nv;
  logic [16:0] exp_q[$];  // Notes: check flag, read value
  logic [16:0] e_m;       // Note being compared
  logic [31:0] rnd;       // Random state
  int          n_mismatch, comparisons, cycles;

  rom_top #(.BLINK_CYC(BL), .RESTART_CYC(3), .SETTLE_CYC(5)) dut (
    .mclk_i(clk), .rst_b_i(rst_b), .meas_u0_i(u0), .meas_i0_i(i0),
    .meas_idir_i(idir), .meas_angle_i(ang), .angle_ok_i(ang_ok),
    .bin_in_i(bin), .stage_start_i(st), .stage_trip_i(tr),
    .fault_i(flt), .fault_code_i(fcode), .par_rd_i(rd), .par_wr_i(wr),
    .par_sel_i(sel), .par_wdata_i(wd), .par_rdata_o(rdata),
    .par_ack_o(ack), .trip_a_o(ta), .trip_b_o(tb), .sig_a_o(sa),
    .sig_b_o(sb), .sup_energ_o(sup), .ready_led_o(rdy),
    .fault_msg_o(msg), .ind_o(ind), .restart_o(rq), .ext_block_o(blk),
    .set_bank_o(bank), .rec_trig_o(trg), .nom_volt_o(nv));
  rom_host_model host (.mclk_i(clk), .ack_i(ack), .rd_o(rd), .wr_o(wr),
    .sel_o(sel), .wdata_o(wd));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input string nm, input logic [15:0] seen, ex);
    comparisons++;
    if (seen !== ex) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, ex, seen);
    end
  endtask : check
  task automatic ck1(input string nm, input logic seen, ex);
    check(nm, 16'(seen), 16'(ex));
  endtask : ck1
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task automatic rd_p(input logic [7:0] s, input logic [15:0] v);
    exp_q.push_back({1'b1, v});
    host.xfer(1'b0, s, 16'h0000);
  endtask : rd_p
  task automatic wr_p(input logic [7:0] s, input logic [15:0] d);
    exp_q.push_back(17'h00000);
    host.xfer(1'b1, s, d);
  endtask : wr_p
  task automatic settle();
    repeat (3) @(negedge clk);
  endtask : settle

  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_mismatch++;
      close_out();
    end
  end
  // Oldest note answers each acknowledged access
  always @(negedge clk) begin
    if (ack === 1'b1 && exp_q.size() > 0) begin
      e_m = exp_q.pop_front();
      if (e_m[16]) check("par_rdata_o", rdata, e_m[15:0]);
    end
  end

  initial begin
    int k;
    int t;
    logic p;
    {ang_ok, bin, st, tr, flt, fcode, u0, i0, idir, ang} = '0;
    rst_b = 1'b0;
    rnd   = 32'h40DCFF5B;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    rd_p(rom_pkg::P_ENABLE, 16'h0001);
    for (k = 0; k < 6; k++)
      rd_p(rom_pkg::P_GROUP_BASE + k[7:0], k[0] ? 16'h0003 : 16'h000C);
    // Measured values; writes there are ignored
    repeat (2) begin
      rnd = lfsr(rnd);
      {u0, i0} = rnd;
      rnd = lfsr(rnd);
      {idir, ang} = rnd;
      ang_ok = 1'b1;
      wr_p(rom_pkg::P_MEAS_U0, ~u0);
      rd_p(rom_pkg::P_MEAS_U0, u0);
      rd_p(rom_pkg::P_MEAS_I0, i0);
      rd_p(rom_pkg::P_MEAS_IDIR, idir);
      rd_p(rom_pkg::P_MEAS_ANGLE, ang);
    end
    ang_ok = 1'b0;
    rd_p(rom_pkg::P_MEAS_ANGLE, 16'h03E7);
    for (k = 0; k < 2; k++) begin
      bin = k[0];
      settle();
      rd_p(rom_pkg::P_BIN_STATE, k[15:0]);
    end
    bin = 1'b0;
    // Random stage flags under factory routing
    repeat (3) begin
      rnd = lfsr(rnd);
      st = {rnd[4], rnd[2], rnd[0]};
      tr = {rnd[5], rnd[3], rnd[1]};
      settle();
      for (k = 0; k < 6; k++)
        rd_p(rom_pkg::P_STAGE_BASE + k[7:0], 16'(rnd[k]));
      p = |tr;
      for (k = 0; k < 4; k++)
        rd_p(rom_pkg::P_CONT_BASE + k[7:0], 16'(k < 2 ? p : |st));
    end
    st = 3'b000;
    tr = 3'b000;
    // Low trip to trip a only, high trip to signal b only
    wr_p(rom_pkg::P_GROUP_BASE + 8'h01, 16'h0001);
    wr_p(rom_pkg::P_GROUP_BASE + 8'h05, 16'h0008);
    tr = 3'b001;
    settle();
    for (k = 0; k < 4; k++)
      rd_p(rom_pkg::P_CONT_BASE + k[7:0], 16'(k == 0));
    tr = 3'b100;
    settle();
    for (k = 0; k < 4; k++)
      rd_p(rom_pkg::P_CONT_BASE + k[7:0], 16'(k == 3));
    tr = 3'b000;
    settle();
    wr_p(rom_pkg::P_REC_CLEAR, 16'h03FF);
    tr = 3'b001;
    settle();
    tr = 3'b000;
    settle();
    for (k = 0; k < 10; k++)
      rd_p(rom_pkg::P_REC_BASE + k[7:0], 16'(k == 1 || k == 6));
    // Global enable, then a forced contact and its unlatch
    wr_p(rom_pkg::P_ENABLE, 16'h0000);
    tr = 3'b001;
    settle();
    rd_p(rom_pkg::P_CONT_BASE, 16'h0000);
    wr_p(rom_pkg::P_ENABLE, 16'h0001);
    settle();
    rd_p(rom_pkg::P_CONT_BASE, 16'h0001);
    tr = 3'b000;
    wr_p(rom_pkg::P_CONT_BASE + 8'h03, 16'h0001);
    settle();
    rd_p(rom_pkg::P_CONT_BASE + 8'h03, 16'h0001);
    wr_p(rom_pkg::P_BIN_FUNC, 16'(rom_pkg::ROM_BI_UNLATCH));
    bin = 1'b1;
    settle();
    rd_p(rom_pkg::P_CONT_BASE + 8'h03, 16'h0000);
    bin = 1'b0;
    wr_p(rom_pkg::P_BIN_FUNC, 16'(rom_pkg::ROM_BI_BLOCK));
    bin = 1'b1;
    settle();
    ck1("ext_block_o", blk, 1'b1);
    ck1("set_bank_o", bank, 1'b0);
    bin = 1'b0;
    wr_p(rom_pkg::P_BIN_FUNC, 16'(rom_pkg::ROM_BI_SETTINGS));
    bin = 1'b1;
    settle();
    ck1("set_bank_o", bank, 1'b1);
    bin = 1'b0;
    wr_p(rom_pkg::P_REC_TRIG, 16'h0001);
    settle();
    bin = 1'b1;
    t   = 0;
    repeat (4) begin
      @(negedge clk);
      if (trg === 1'b1) t++;
    end
    ck1("rec_trig_o", t == 1, 1'b1);
    bin = 1'b0;
    for (k = 0; k < 4; k++) begin
      wr_p(rom_pkg::P_NOM_VOLT, k[15:0]);
      settle();
      check("nom_volt_o", 16'(nv), k[15:0]);
      rd_p(rom_pkg::P_NOM_VOLT, k[15:0]);
    end
    // Lasting fault with a mid trip pending
    tr    = 3'b010;
    fcode = 8'h5A;
    flt   = 1'b1;
    repeat (2) @(negedge clk);
    ck1("restart_o", rq, 1'b1);
    ck1("sup_energ_o", sup, 1'b1);
    repeat (12) @(negedge clk);
    ck1("sup_energ_o", sup, 1'b0);
    ck1("fault_msg_o", msg, 1'b1);
    check("ind_o", 16'(ind), 16'h0000);
    for (k = 0; k < 4; k++)
      rd_p(rom_pkg::P_CONT_BASE + k[7:0], 16'h0000);
    p = rdy;
    t = 0;
    repeat (4 * BL + 2) begin
      @(negedge clk);
      if (rdy !== p) t++;
      p = rdy;
    end
    ck1("ready_led_o", t >= 3, 1'b1);
    wr_p(rom_pkg::P_FAULT_CLEAR, 16'h0001);
    settle();
    ck1("fault_msg_o", msg, 1'b1);
    rd_p(rom_pkg::P_FAULT_CODE, 16'h005A);
    flt = 1'b0;
    settle();
    ck1("sup_energ_o", sup, 1'b1);
    ck1("ready_led_o", rdy, 1'b1);
    ck1("fault_msg_o", msg, 1'b1);
    rd_p(rom_pkg::P_CONT_BASE, 16'h0001);
    wr_p(rom_pkg::P_FAULT_CLEAR, 16'h0001);
    settle();
    ck1("fault_msg_o", msg, 1'b0);
    check("ind_o", 16'(ind), 16'h0002);
    fcode = 8'hA5;
    flt   = 1'b1;
    repeat (2) @(negedge clk);
    flt = 1'b0;
    repeat (12) @(negedge clk);
    rd_p(rom_pkg::P_FAULT_CODE, 16'h00A5);
    repeat (4) @(negedge clk);
    close_out();
  end
endmodule : test_relay_output_matrix_and_supervision
`default_nettype wire

/* verilog/rom_top.sv */
// Output matrix, recorded flags and self-supervision of the relay.
// Assumes measured values, stage flags and the fault detector arrive
// synchronous to mclk_i; the host reaches it over the parameter port.
//
// Contract
// - Binary input parameter reads 1 when energized
// - Measured values readable, read-only
// - Invalid phase angle reads as +999
// - Six readable stage start/trip flags
// - Host reads and writes each contact state
// - Rising source sets its recorded flag
// - One enable bit gates the four output contacts, not the supervision relay
// - Fault first answered by a restart attempt
// - Permanent fault: blink, supervision contact, message
// - Fault blocks all other contacts
// - Fault indication overrides other indications
// - Fault clear ignored while ready blinks
// - Fault gone: normal contact, message stays
// - Fault code holds last detected fault
// - Binary input function chosen by selector
// - Binary input may trigger disturbance recorder
// - Switches 1,2 route trips to trip contacts
// - Factory trips drive both trip contacts
// - Switches 3,4 route to signalling contacts
// - Factory starts drive both signalling contacts
// - Supervision relay energized unless permanent fault
// - Nominal voltage selection applied from setting
`timescale 1ns/1ps
`default_nettype none

module rom_top #(
  parameter int unsigned DW          = 16,  // Parameter data width
  parameter int unsigned NSTAGE      = 3,   // Protection stages
  parameter int unsigned BLINK_CYC   = rom_pkg::BLINK_HALF_CYC,
  parameter int unsigned RESTART_CYC = rom_pkg::RESTART_CYC,
  parameter int unsigned SETTLE_CYC  = rom_pkg::SETTLE_CYC
) (
  input  wire logic              mclk_i,        // System clock
  input  wire logic              rst_b_i,       // Async reset, low
  input  wire logic [15:0]       meas_u0_i,     // Residual voltage
  input  wire logic [15:0]       meas_i0_i,     // Earth-fault current
  input  wire logic [15:0]       meas_idir_i,   // Directional current
  input  wire logic [15:0]       meas_angle_i,  // Phase angle
  input  wire logic              angle_ok_i,    // Angle evaluable
  input  wire logic              bin_in_i,      // Binary input level
  input  wire logic [NSTAGE-1:0] stage_start_i, // Stage starts
  input  wire logic [NSTAGE-1:0] stage_trip_i,  // Stage trips
  input  wire logic              fault_i,       // Fault detector
  input  wire logic [7:0]        fault_code_i,  // Fault type
  input  wire logic              par_rd_i,      // Parameter read
  input  wire logic              par_wr_i,      // Parameter write
  input  wire logic [7:0]        par_sel_i,     // Parameter code
  input  wire logic [DW-1:0]     par_wdata_i,   // Write data
  output logic [DW-1:0]          par_rdata_o,   // Read data
  output logic                   par_ack_o,     // Access done
  output logic                   trip_a_o,      // Trip contact a
  output logic                   trip_b_o,      // Trip contact b
  output logic                   sig_a_o,       // Signal contact a
  output logic                   sig_b_o,       // Signal contact b
  output logic                   sup_energ_o,   // Supervision coil
  output logic                   ready_led_o,   // Ready indicator
  output logic                   fault_msg_o,   // Fault message shown
  output logic [1:0]             ind_o,         // Start/trip indicators
  output logic                   restart_o,     // Self restart request
  output logic                   ext_block_o,   // External blocking
  output logic                   set_bank_o,    // Remote settings bank
  output logic                   rec_trig_o,    // Recorder trigger
  output logic [1:0]             nom_volt_o     // Nominal voltage code
);
  localparam int unsigned NSIG = 2 * NSTAGE;  // Stage flags
  localparam int unsigned NREC = NSIG + 4;    // Recorded sources

  // Refuse shapes the parameter map cannot carry
  if (NSTAGE != 3 || DW < 16 || BLINK_CYC < 1 || RESTART_CYC < 1
      || SETTLE_CYC < 1) begin : g_bad
    $error("rom_top: unsupported parameter values");
  end

  typedef enum logic [1:0] {
    ROM_OK,
    ROM_RESTART,
    ROM_SETTLE,
    ROM_PERM
  } rom_sup_t;

  // Range decode, used for every indexed parameter family
  function automatic logic in_rng(input logic [7:0] sel,
                                  input logic [7:0] base,
                                  input int unsigned n);
    in_rng = (sel >= base) && ({24'h0, sel} < {24'h0, base} + n);
  endfunction : in_rng

  logic [NSIG-1:0]  stage_r;     // Bit 2k start, 2k+1 trip
  logic [NSIG-1:0]  stage_nxt;   // Stage flags, not yet sampled
  logic             bin_r;       // Sampled binary input
  logic [3:0]       force_r;     // Host-written contact states
  logic [3:0]       cont_r;      // Physical contact states
  logic [3:0]       cont_nxt;    // Next contact states
  logic [3:0]       routed;      // Matrix outputs
  logic [NREC-1:0]  rec_r;       // Recorded flags
  logic             en_r;        // Global contact enable
  logic [3:0]       grp_r [NSIG]; // Routing groups
  logic [1:0]       bi_func_r;   // Binary input function
  logic             trig_sel_r;  // Recorder trigger select
  logic [7:0]       code_r;      // Last fault code
  logic             fault_q_r;   // Fault level, last cycle
  rom_sup_t         sup_r;       // Supervision state
  logic [31:0]      tmr_r;       // Restart and settle timer
  logic [31:0]      blink_r;     // Blink divider
  logic             blinking;    // Ready indicator blinking

  assign blinking  = (sup_r == ROM_PERM);
  assign stage_nxt = {stage_trip_i[2], stage_start_i[2],
                      stage_trip_i[1], stage_start_i[1],
                      stage_trip_i[0], stage_start_i[0]};

  // Routing matrix: each contact ORs the stages whose switch is set
  for (genvar c = 0; c < 4; c++) begin : g_route
    logic [NSIG-1:0] hit;
    for (genvar s = 0; s < NSIG; s++) begin : g_sig
      assign hit[s] = stage_r[s] & grp_r[s][c];
    end
    assign routed[c] = |hit;
  end

  // Fault blocks everything but the supervision relay
  assign cont_nxt = (routed | force_r) & {4{en_r & ~fault_i}};

  // Input sampling and contact drive; state reflects the contact
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stage_r   <= '0;
      bin_r     <= 1'b0;
      fault_q_r <= 1'b0;
      cont_r    <= '0;
    end else begin
      stage_r   <= stage_nxt;
      bin_r     <= bin_in_i;
      fault_q_r <= fault_i;
      cont_r    <= cont_nxt;
    end
  end
  assign {sig_b_o, sig_a_o, trip_b_o, trip_a_o} = cont_r;

  // Recorded flags; a new rising edge wins over a same-cycle clear
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rec_r <= '0;
    end else begin
      if (par_wr_i && par_sel_i == rom_pkg::P_REC_CLEAR) begin
        rec_r <= rec_r & ~par_wdata_i[NREC-1:0];
      end
      for (int i = 0; i < NREC; i++) begin
        if (i < NSIG) begin
          if (stage_nxt[i] && !stage_r[i]) begin
            rec_r[i] <= 1'b1;
          end
        end else if (cont_nxt[i-NSIG] && !cont_r[i-NSIG]) begin
          rec_r[i] <= 1'b1;
        end
      end
    end
  end

  // Host-forced contact states; unlatch via binary input drops them
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      force_r <= '0;
    end else if (bin_in_i && !bin_r
                 && bi_func_r == 2'(rom_pkg::ROM_BI_UNLATCH)) begin
      force_r <= '0;
    end else if (par_wr_i && in_rng(par_sel_i, rom_pkg::P_CONT_BASE, 4)) begin
      force_r[2'(par_sel_i - rom_pkg::P_CONT_BASE)] <= par_wdata_i[0];
    end
  end

  // Settings registers: enable, groups, selectors
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      en_r       <= rom_pkg::ENABLE_RST;
      bi_func_r  <= 2'(rom_pkg::ROM_BI_NONE);
      trig_sel_r <= 1'b0;
      nom_volt_o <= rom_pkg::NOM_VOLT_RST;
      for (int s = 0; s < NSIG; s++) begin
        grp_r[s] <= s[0] ? rom_pkg::GRP_TRIP_RST
                         : rom_pkg::GRP_START_RST;
      end
    end else if (par_wr_i) begin
      if (par_sel_i == rom_pkg::P_ENABLE) begin
        en_r <= par_wdata_i[0];
      end
      if (par_sel_i == rom_pkg::P_BIN_FUNC) begin
        bi_func_r <= par_wdata_i[1:0];
      end
      if (par_sel_i == rom_pkg::P_REC_TRIG) begin
        trig_sel_r <= par_wdata_i[0];
      end
      if (par_sel_i == rom_pkg::P_NOM_VOLT) begin
        nom_volt_o <= par_wdata_i[1:0];
      end
      if (in_rng(par_sel_i, rom_pkg::P_GROUP_BASE, NSIG)) begin
        grp_r[3'(par_sel_i - rom_pkg::P_GROUP_BASE)] <= par_wdata_i[3:0];
      end
    end
  end

  // Binary input side functions
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ext_block_o <= 1'b0;
      set_bank_o  <= 1'b0;
      rec_trig_o  <= 1'b0;
    end else begin
      ext_block_o <= bin_in_i
                     && bi_func_r == 2'(rom_pkg::ROM_BI_BLOCK);
      set_bank_o  <= bin_in_i
                     && bi_func_r == 2'(rom_pkg::ROM_BI_SETTINGS);
      rec_trig_o  <= trig_sel_r && bin_in_i && !bin_r;
    end
  end

  // Supervision: restart first, declare permanent only if it persists
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sup_r <= ROM_OK;
      tmr_r <= '0;
    end else begin
      unique case (sup_r)
        ROM_OK: begin
          if (fault_i) begin
            sup_r <= ROM_RESTART;
            tmr_r <= '0;
          end
        end
        ROM_RESTART: begin
          if (tmr_r == RESTART_CYC - 1) begin // Fixed restart pulse
            sup_r <= ROM_SETTLE;
            tmr_r <= '0;
          end else begin
            tmr_r <= tmr_r + 32'h1;
          end
        end
        ROM_SETTLE: begin
          if (!fault_i) begin // Recovered by the restart
            sup_r <= ROM_OK;
          end else if (tmr_r == SETTLE_CYC - 1) begin
            sup_r <= ROM_PERM;
          end else begin
            tmr_r <= tmr_r + 32'h1;
          end
        end
        ROM_PERM: begin
          if (!fault_i) begin
            sup_r <= ROM_OK;
          end
        end
      endcase
    end
  end

  // Supervision outputs and the blink divider
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      blink_r     <= '0;
      ready_led_o <= 1'b0;
      sup_energ_o <= 1'b0;
      restart_o   <= 1'b0;
    end else begin
      restart_o   <= (sup_r == ROM_RESTART);
      sup_energ_o <= !blinking;
      if (!blinking) begin
        blink_r     <= '0;
        ready_led_o <= 1'b1;    // Steady when healthy
      end else if (blink_r == BLINK_CYC - 1) begin
        blink_r     <= '0;
        ready_led_o <= !ready_led_o;
      end else begin
        blink_r     <= blink_r + 32'h1;
      end
    end
  end

  // Fault message latch; survives recovery, cleared only when steady
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fault_msg_o <= 1'b0;
    end else if (blinking) begin
      fault_msg_o <= 1'b1;
    end else if (par_wr_i && par_sel_i == rom_pkg::P_FAULT_CLEAR) begin
      fault_msg_o <= 1'b0;
    end
  end

  // Fault code, overwritten on every new detection
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      code_r <= '0;
    end else if (fault_i && !fault_q_r) begin
      code_r <= fault_code_i;
    end
  end

  // Start/trip indicators, suppressed under a fault message
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ind_o <= '0;
    end else if (fault_msg_o || blinking) begin
      ind_o <= '0;
    end else begin
      ind_o <= {|(stage_r & 6'h2A), |(stage_r & 6'h15)};
    end
  end

  // Parameter read port; one-cycle ack, unmapped codes read zero
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      par_rdata_o <= '0;
      par_ack_o   <= 1'b0;
    end else begin
      par_ack_o <= par_rd_i || par_wr_i;
      if (par_rd_i) begin
        par_rdata_o <= '0;
        unique case (1'b1)
          par_sel_i == rom_pkg::P_MEAS_U0:
            par_rdata_o[15:0] <= meas_u0_i;
          par_sel_i == rom_pkg::P_MEAS_I0:
            par_rdata_o[15:0] <= meas_i0_i;
          par_sel_i == rom_pkg::P_MEAS_IDIR:
            par_rdata_o[15:0] <= meas_idir_i;
          par_sel_i == rom_pkg::P_MEAS_ANGLE:
            par_rdata_o[15:0] <= angle_ok_i ? meas_angle_i
                                 : rom_pkg::ANGLE_INVALID;
          par_sel_i == rom_pkg::P_BIN_STATE: par_rdata_o[0] <= bin_r;
          in_rng(par_sel_i, rom_pkg::P_STAGE_BASE, NSIG):
            par_rdata_o[0] <= stage_r[3'(par_sel_i
                              - rom_pkg::P_STAGE_BASE)];
          in_rng(par_sel_i, rom_pkg::P_CONT_BASE, 4):
            par_rdata_o[0] <= cont_r[2'(par_sel_i
                              - rom_pkg::P_CONT_BASE)];
          in_rng(par_sel_i, rom_pkg::P_REC_BASE, NREC):
            par_rdata_o[0] <= rec_r[4'(par_sel_i
                              - rom_pkg::P_REC_BASE)];
          par_sel_i == rom_pkg::P_ENABLE: par_rdata_o[0] <= en_r;
          in_rng(par_sel_i, rom_pkg::P_GROUP_BASE, NSIG):
            par_rdata_o[3:0] <= grp_r[3'(par_sel_i
                                - rom_pkg::P_GROUP_BASE)];
          par_sel_i == rom_pkg::P_BIN_FUNC: par_rdata_o[1:0] <= bi_func_r;
          par_sel_i == rom_pkg::P_NOM_VOLT: par_rdata_o[1:0] <= nom_volt_o;
          par_sel_i == rom_pkg::P_REC_TRIG: par_rdata_o[0] <= trig_sel_r;
          par_sel_i == rom_pkg::P_FAULT_CLEAR: par_rdata_o[0] <= fault_msg_o;
          par_sel_i == rom_pkg::P_FAULT_CODE:
            par_rdata_o[7:0] <= code_r;
          default: par_rdata_o <= '0; // Unmapped code
        endcase
      end
    end
  end
endmodule : rom_top

`default_nettype wire
